// File: verilog/iifs_pkg.sv
// What this block does
// - The filter time is the setting code times 20 ms, so 20 ms to 2540 ms.
// - A filter-settings length of zero turns input filtering off.
// - A new setting is taken while running, with no switch to change.
// - The status word is returned only when its length is 16; it defaults to 0.
// - Internal status is carried in the lowest eleven bits of the status word.
// - Status bit 9 is high while the module is not ready.
// - The terminal block indicator is green when latched and red when not.
// - A change of the latched state sends an attached or detached message.
// - Response uncertainty stays within one filter step of the set time.
// - Sixteen independent points each have an indicator of their state.
package iifs_pkg;
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned STEP_MS      = 20;
  localparam int unsigned STEP_CYCLES  = CLK_HZ / 1000 * STEP_MS;
  localparam int unsigned DIV_W        = 18;
  localparam int unsigned POINTS       = 16;
  localparam int unsigned CODE_W       = 7;
  localparam logic [4:0]  LEN_ON       = 5'h10;
  localparam logic [4:0]  LEN_OFF      = 5'h00;
  localparam logic [6:0]  CODE_MIN     = 7'h01;
  localparam logic [6:0]  CODE_RST     = 7'h01;
  localparam int unsigned ST_TB_OPEN   = 0;
  localparam int unsigned ST_BAD_CODE  = 1;
  localparam int unsigned ST_NOT_READY = 9;
  localparam int unsigned ST_USED_BITS = 11;
endpackage

// File: verilog/iifs_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface iifs_ctl_if;
  logic       tick;
  logic       en;
  logic [6:0] code;
  modport src  (output tick, output en, output code);
  modport sink (input tick, input en, input code);
endinterface
`default_nettype wire

// File: verilog/iifs_point_filter.sv
`timescale 1ns/1ps
`default_nettype none
module iifs_point_filter (
  // Clock and reset.
  input  wire logic  ref_clk,
  input  wire logic  rst,
  // Shared filter control.
  iifs_ctl_if.sink   ctl,
  // Point level.
  input  wire logic  raw_in,
  output logic       level_out
);
  typedef struct packed {
    logic       level;
    logic [6:0] cnt;
  } iifs_pf_state_t;

  iifs_pf_state_t s_q;
  iifs_pf_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (!ctl.en) begin
      s_d.level = raw_in;
      s_d.cnt   = '0;
    end else if (raw_in == s_q.level) begin
      s_d.cnt = '0;
    end else if (ctl.tick) begin
      // The first step is partial, so the hold is code-1 to code steps.
      if (s_q.cnt + 7'h01 >= ctl.code) begin
        s_d.level = raw_in;
        s_d.cnt   = '0;
      end else begin
        s_d.cnt = s_q.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.level;
endmodule
`default_nettype wire

// File: verilog/iifs_top.sv
`timescale 1ns/1ps
`default_nettype none
module iifs_top #(
  parameter int unsigned STEP_CYCLES = iifs_pkg::STEP_CYCLES
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Field inputs and point indicators.
  input  wire logic [15:0] field_in,
  output logic      [15:0] input_state,
  output logic      [15:0] point_led,
  // Filter configuration from the controller.
  input  wire logic [4:0]  filter_len,
  input  wire logic [7:0]  filter_code,
  // Status word to the controller.
  input  wire logic [4:0]  status_len,
  output logic      [15:0] status_word,
  output logic             status_valid,
  // Terminal block.
  input  wire logic        tb_latched,
  output logic             terminal_block_indicator_green,
  output logic             terminal_block_indicator_red,
  output logic             block_attached_message,
  output logic             block_detached_message
);
  typedef struct packed {
    logic [iifs_pkg::DIV_W-1:0] div;
    logic                       tick;
    logic [6:0]                 code;
    logic                       bad_code;
    logic                       ready;
    logic                       tb;
    logic                       attach;
    logic                       detach;
    logic [15:0]                status;
    logic                       status_vld;
  } iifs_top_state_t;

  iifs_top_state_t s_q;
  iifs_top_state_t s_d;
  logic [15:0]     levels;
  logic            code_ok;
  logic            filt_en;

  iifs_ctl_if ctl ();

  assign code_ok = (filter_code[7] == 1'b0)
                   && (filter_code[6:0] >= iifs_pkg::CODE_MIN);
  assign filt_en = (filter_len != iifs_pkg::LEN_OFF);

  always_comb begin
    s_d        = s_q;
    s_d.tick   = 1'b0;
    s_d.attach = 1'b0;
    s_d.detach = 1'b0;
    if (s_q.div == iifs_pkg::DIV_W'(STEP_CYCLES - 1)) begin
      s_d.div  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + iifs_pkg::DIV_W'(1);
    end
    // A code out of range is refused and the last good one stays in use.
    if (code_ok) begin
      s_d.code     = filter_code[6:0];
      s_d.bad_code = 1'b0;
      s_d.ready    = 1'b1;
    end else begin
      s_d.bad_code = 1'b1;
    end
    if (!filt_en) begin
      s_d.ready = 1'b1;
    end
    s_d.tb = tb_latched;
    if (tb_latched && !s_q.tb) begin
      s_d.attach = 1'b1;
    end
    if (!tb_latched && s_q.tb) begin
      s_d.detach = 1'b1;
    end
    s_d.status_vld = (status_len == iifs_pkg::LEN_ON);
    s_d.status     = '0;
    if (s_d.status_vld) begin
      s_d.status[iifs_pkg::ST_TB_OPEN]   = !tb_latched;
      s_d.status[iifs_pkg::ST_BAD_CODE]  = s_d.bad_code;
      s_d.status[iifs_pkg::ST_NOT_READY] = !s_d.ready;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q      <= '0;
      s_q.code <= iifs_pkg::CODE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign ctl.tick = s_q.tick;
  assign ctl.en   = filt_en;
  assign ctl.code = s_q.code;

  genvar gi;
  generate
    for (gi = 0; gi < iifs_pkg::POINTS; gi++) begin : g_pt
      iifs_point_filter u_pf (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .ctl       (ctl),
        .raw_in    (field_in[gi]),
        .level_out (levels[gi])
      );
    end
  endgenerate

  assign input_state                    = levels;
  assign point_led                      = levels;
  assign status_word                    = s_q.status;
  assign status_valid                   = s_q.status_vld;
  assign terminal_block_indicator_green = s_q.tb;
  assign terminal_block_indicator_red   = !s_q.tb;
  assign block_attached_message         = s_q.attach;
  assign block_detached_message         = s_q.detach;
endmodule
`default_nettype wire

// File: testbench/iifs_props.sv
`timescale 1ns/1ps
`default_nettype none
module iifs_props (
  // Watched ports.
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [15:0] field_in,
  input wire logic [15:0] input_state,
  input wire logic [4:0]  filter_len,
  input wire logic [4:0]  status_len,
  input wire logic [15:0] status_word,
  input wire logic        tb_latched,
  input wire logic        terminal_block_indicator_green,
  input wire logic        terminal_block_indicator_red,
  input wire logic        block_attached_message,
  input wire logic        block_detached_message
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  led_color_a: assert property (terminal_block_indicator_red
    != terminal_block_indicator_green) else $error("tb led");
  led_track_a: assert property (terminal_block_indicator_green
    == $past(tb_latched)) else $error("tb green");
  attach_msg_a: assert property ($rose(tb_latched) |=>
    block_attached_message ##1 !block_attached_message) else $error("add");
  detach_msg_a: assert property ($fell(tb_latched) |=>
    block_detached_message ##1 !block_detached_message) else $error("lost");
  status_off_a: assert property (status_len != 5'h10 |=>
    status_word == 16'h0000) else $error("status off");
  status_bits_a: assert property (status_word[15:11] == 5'h00)
    else $error("status bits");
  filter_off_a: assert property ($past(filter_len) == 5'h00 &&
    filter_len == 5'h00 |=> input_state == $past(field_in)) else $error("off");
  state_src_a: assert property ($changed(input_state[0]) |->
    input_state[0] == $past(field_in[0])) else $error("state");
endmodule
bind iifs_top iifs_props iifs_props_i (.*);
`default_nettype wire

// File: testbench/iifs_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module iifs_cpu_model (
  // Settings.
  input  wire logic       ref_clk,
  input  wire logic [7:0] code_req,
  output logic      [7:0] filter_code = 8'h00
);
  always @(posedge ref_clk) filter_code <= code_req;
endmodule
`default_nettype wire

// File: testbench/iifs_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module iifs_top_bench;
  logic        ref_clk = 1'b0, rst = 1'b1, tb_latched = 1'b0;
  logic        terminal_block_indicator_green, terminal_block_indicator_red;
  logic        block_attached_message, block_detached_message, status_valid;
  logic [4:0]  filter_len = 5'h10, status_len = 5'h10;
  logic [7:0]  code_req = 8'h00, filter_code;
  logic [15:0] field_in = 16'h0000, input_state, point_led, status_word;
  // Rows: green, valid, tb_latched, status_len, then the status word.
  logic [23:0] rows [3] = '{24'ha00000, 24'hf00000, 24'h500001};
  int          err_count = 0, checks = 0, cyc = 0;
  iifs_cpu_model iifs_cpu_model_i (.*);
  iifs_top #(.STEP_CYCLES(10)) iifs_top_i (.*);
  initial forever #50 ref_clk = ~ref_clk;
  // The tests need about 150 cycles, so 400 means the run has hung.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 400) begin
      err_count++;
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Waits n cycles from just after an edge, so inputs stay off the edge.
  task automatic pause(int n);
    #(100 * n);
  endtask
  task automatic check(string s, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %0s expected %h seen %h", s, e, g);
    end
    $display("test %0s done", s);
  endtask
  initial begin
    #51;
    pause(5);
    check("reset", 16'h0000, status_word);
    check("reset red", 16'h0001, 16'(terminal_block_indicator_red));
    rst = 1'b0;
    pause(4);
    check("not ready", 16'h0203, status_word);
    code_req = 8'h03;
    foreach (rows[i]) begin
      {tb_latched, status_len} = rows[i][21:16];
      pause(4);
      check("table", rows[i][15:0], status_word);
      check("valid", 16'(rows[i][22]), 16'(status_valid));
      check("tb", 16'(rows[i][23]), 16'(terminal_block_indicator_green));
    end
    field_in = 16'h0001;
    pause(15);
    check("early", 16'h0000, input_state);
    pause(25);
    check("held", 16'h0001, input_state);
    field_in = 16'h0003;
    pause(5);
    check("pulse", 16'h0001, input_state);
    field_in = 16'h0001;
    pause(40);
    check("glitch", 16'h0001, input_state);
    code_req = 8'h01;
    field_in = 16'h0000;
    pause(14);
    check("new code", 16'h0000, input_state);
    code_req = 8'h83;
    pause(4);
    check("refused", 16'h0003, status_word);
    field_in = 16'h0001;
    pause(15);
    check("code kept", 16'h0001, input_state);
    filter_len = 5'h00;
    field_in = 16'ha5a5;
    pause(4);
    check("bypass", 16'ha5a5, point_led);
    rst = 1'b1;
    pause(2);
    check("mid reset", 16'h0000, input_state);
    check("mid status", 16'h0000, status_word);
    rst = 1'b0;
    pause(4);
    check("after reset", 16'ha5a5, input_state);
    check("off ready", 16'h0003, status_word);
    tally_and_finish;
  end
endmodule
`default_nettype wire
